// file: bench/kps_keypad_scan_sva.sv
/* Port checker for the keypad scanner.
   Assumes it is bound onto kps_keypad_scan with one clock domain. */
`timescale 1ns/1ps
module kps_keypad_scan_sva
#(
    parameter int unsigned SAMPLE_CYC = 1000
)
(
    input  wire logic            clock,
    input  wire logic            rstn,
    input  kps_pkg::kps_reg_req_t reg_req,
    input  wire logic [7:0]      reg_rdata,
    input  wire logic            reg_rvalid,
    input  wire logic [7:0]      row_in,
    input  wire logic [7:0]      row_out,
    input  wire logic [7:0]      row_oe,
    input  wire logic [7:0]      row_pullup_en,
    input  wire logic [9:0]      col_in,
    input  wire logic [9:0]      col_out,
    input  wire logic [9:0]      col_oe,
    input  wire logic [9:0]      col_pullup_en,
    input  wire logic            int_n_out,
    input  wire logic            int_n_oe
);
    import kps_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    // ----
    // Port relations
    // ----
    property p_rv; reg_req.rd |=> reg_rvalid; endproperty
    a_rv: assert property (p_rv)
        else $error("read not answered");
    property p_rv1; !reg_req.rd |=> !reg_rvalid; endproperty
    a_rv1: assert property (p_rv1)
        else $error("answer without read");
    property p_rows; row_oe == 8'h00 && row_out == 8'h00; endproperty
    a_rows: assert property (p_rows)
        else $error("row line driven");
    property p_cols; col_out == 10'h000; endproperty
    a_cols: assert property (p_cols)
        else $error("column not driven low");
    property p_pull; row_pullup_en == 8'hff && col_pullup_en == 10'h3ff;
    endproperty
    a_pull: assert property (p_pull)
        else $error("pull-up off");
    property p_od; int_n_out == 1'b0; endproperty
    a_od: assert property (p_od)
        else $error("interrupt pin driven high");
    // Key field stays 1..80 and a zero key means an all-zero byte
    property p_key;
        reg_rvalid && $past(reg_req.addr) inside {[8'h04:8'h0d]} |->
        reg_rdata[6:0] <= 7'h50 &&
        (reg_rdata[6:0] != 7'h00 || reg_rdata == 8'h00);
    endproperty
    a_key: assert property (p_key)
        else $error("bad event byte");
    property p_unmap; reg_req.rd && reg_req.addr == 8'h00 |=>
        reg_rdata == 8'h00; endproperty
    a_unmap: assert property (p_unmap)
        else $error("unmapped read not zero");
    c_press: cover property (reg_rvalid && reg_rdata[7]);
    c_rel: cover property (reg_rvalid && reg_rdata[6:0] != 7'h00 &&
        !reg_rdata[7]);
    c_irq: cover property ($rose(int_n_oe));
endmodule
bind kps_keypad_scan kps_keypad_scan_sva #(.SAMPLE_CYC(SAMPLE_CYC)) i_sva
    (.clock(clock), .rstn(rstn), .reg_req(reg_req), .reg_rdata(reg_rdata),
     .reg_rvalid(reg_rvalid), .row_in(row_in), .row_out(row_out),
     .row_oe(row_oe), .row_pullup_en(row_pullup_en), .col_in(col_in),
     .col_out(col_out), .col_oe(col_oe), .col_pullup_en(col_pullup_en),
     .int_n_out(int_n_out), .int_n_oe(int_n_oe));

// file: bench/kps_keypad_scan_tb.sv
/* Self-checking bench for the keypad scanner and its event FIFO.
   Assumes the matrix model on the pins and the strobe register port. */
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
    cmp_count++; \
    if ((got) !== (ex)) \
    begin \
        miscompares++; \
        $display("Error %s expected %h seen %h", nm, ex, got); \
    end
module kps_keypad_scan_tb;
    import kps_pkg::*;
    localparam int unsigned SC = 1000;
    logic            clock = 1'b0;
    logic            rstn = 1'b0;
    kps_reg_req_t    reg_req = '0;
    logic [7:0]      reg_rdata, row_in, row_out, row_oe, row_pu, v;
    logic [9:0]      col_in, col_out, col_oe, col_pu;
    logic            int_n_out, int_n_oe, reg_rvalid;
    logic [7:0][9:0] keys_down = '0;
    logic [31:0]     seed = 32'd63954;
    logic [7:0]      q[$];
    logic            ovf_exp = 1'b0;
    logic            wrap_m = 1'b0;
    int              miscompares = 0;
    int              cmp_count = 0;
    int              cyc = 0;

    always #2.5 clock = ~clock;

    kps_keypad_scan #(.SAMPLE_CYC(SC)) i_kps_keypad_scan
        (.clock(clock), .rstn(rstn), .reg_req(reg_req),
         .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .row_in(row_in),
         .row_out(row_out), .row_oe(row_oe), .row_pullup_en(row_pu),
         .col_in(col_in), .col_out(col_out), .col_oe(col_oe),
         .col_pullup_en(col_pu), .int_n_out(int_n_out),
         .int_n_oe(int_n_oe));
    kps_matrix_model i_kps_matrix_model
        (.col_out(col_out), .col_oe(col_oe), .keys_down(keys_down),
         .row_in(row_in), .col_in(col_in));

    // ----
    // Bus tasks and reference model
    // ----
    task automatic complete_run;
        $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Read data is taken while the one-cycle answer is up
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(negedge clock);
        reg_req = '{1'b1, 1'b0, a, 8'h00};
        @(negedge clock);
        v = reg_rdata;
        reg_req.rd = 1'b0;
        `CHK("register", e, v)
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_req = '{1'b0, 1'b1, a, d};
        @(negedge clock);
        reg_req.wr = 1'b0;
    endtask
    // Full FIFO drops the new event, or the oldest one in wrap mode
    function automatic void push(input logic [7:0] e);
        if (q.size() == 10)
        begin
            ovf_exp = 1'b1;
            if (wrap_m)
                void'(q.pop_front());
        end
        if (q.size() < 10)
            q.push_back(e);
    endfunction
    // Column 9 is left out of the column enables, so its keys log nothing
    task automatic stroke(input int k);
        keys_down[(k-1)/10][(k-1)%10] = 1'b1;
        repeat (3*SC) @(negedge clock);
        if ((k-1) % 10 != 9) push(8'h80 | 8'(k));
        keys_down[(k-1)/10][(k-1)%10] = 1'b0;
        repeat (4*SC) @(negedge clock);
        if ((k-1) % 10 != 9) push(8'(k));
    endtask
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Hang guard well past seven strokes and the drain
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 70000)
        begin
            miscompares++;
            complete_run();
        end
    end

    initial
    begin
        repeat (12) @(posedge clock);
        @(negedge clock) rstn = 1'b1;
        rdc(8'h01, 8'h00);
        rdc(8'h04, 8'h00);
        rdc(8'h00, 8'h00);
        wr(8'h1d, 8'hff);
        wr(8'h1e, 8'hff);
        wr(8'h1f, 8'h01);
        wr(8'h01, 8'h09);
        `CHK("int_n_oe", 1'b0, int_n_oe)
        for (int i = 0; i < 7; i++)
        begin
            // Last stroke runs in wrap mode; with this seed strokes 3 and 7 hit column 9, so neither overflow mode is hit
            if (i == 6)
            begin
                wr(8'h01, 8'h29);
                wrap_m = 1'b1;
                rdc(8'h01, 8'h29);
            end
            seed = xs(seed);
            stroke(int'(seed % 32'd80) + 1);
            rdc(8'h03, 8'(q.size()));
            rdc(8'h02, {4'h0, ovf_exp, 2'b00, q.size() != 0});
            `CHK("int_n_oe", q.size() != 0, int_n_oe)
        end
        $display("Test strokes finished");
        wr(8'h02, 8'h01);
        rdc(8'h02, {4'h0, ovf_exp, 2'b00, q.size() != 0});
        for (int i = 0; i < 10; i++)
        begin
            // A drained FIFO reads as zero and pops nothing
            if (q.size() == 0)
                q.push_back(8'h00);
            rdc(8'h04 + 8'(i), q.pop_front());
            rdc(8'h03, 8'(q.size()));
        end
        rdc(8'h0d, 8'h00);
        wr(8'h02, 8'h09);
        rdc(8'h02, 8'h00);
        `CHK("int_n_oe", 1'b0, int_n_oe)
        $display("Test drain finished");
        complete_run();
    end
endmodule

// file: bench/kps_matrix_model.sv
/* Switch matrix on the far side of the row and column pins.
   Assumes rows and columns carry pull-ups when not driven. */
`timescale 1ns/1ps
module kps_matrix_model
(
    input  wire logic [9:0]      col_out,
    input  wire logic [9:0]      col_oe,
    input  wire logic [7:0][9:0] keys_down,
    output logic [7:0]           row_in,
    output logic [9:0]           col_in
);
    // A closed switch pulls its row down only via a driven-low column
    always_comb
    begin
        for (int r = 0; r < 8; r++)
        begin
            row_in[r] = ~|(keys_down[r] & col_oe & ~col_out);
        end
        col_in = (col_oe & col_out) | ~col_oe;
    end
endmodule

// file: logic/kps_event_fifo.sv
/*
 * Ten-entry key event FIFO with count, overflow pulse and wrap mode.
 * Assumes push and pop come from logic on the same clock.
 */
`timescale 1ns/1ps
module kps_event_fifo
(
    input  wire logic                clock,
    input  wire logic                rstn,
    input  wire logic                push,
    input  kps_pkg::kps_event_t      push_event,
    input  wire logic                wrap_mode,
    input  wire logic                pop,
    output kps_pkg::kps_event_t      head,
    output logic [3:0]               count,
    output logic                     overflow
);
    import kps_pkg::*;

    kps_fifo_t q;
    kps_fifo_t d;

    function automatic logic [3:0] nxt(input logic [3:0] p);
        nxt = (p == KPS_LAST_SLOT) ? 4'd0 : p + 4'd1;
    endfunction

    // A pop in the same cycle frees a slot, so a full FIFO still takes it
    always_comb
    begin
        d     = q;
        d.ovf = 1'b0;
        if (pop && q.cnt != 4'd0)
        begin
            d.rd  = nxt(q.rd);
            d.cnt = d.cnt - 4'd1;
        end
        if (push)
        begin
            if (q.cnt != KPS_FIFO_DEPTH || pop)
            begin
                d.mem[q.wr] = push_event;
                d.wr        = nxt(q.wr);
                d.cnt       = d.cnt + 4'd1;
            end
            else
            begin
                d.ovf = 1'b1;
                if (wrap_mode)
                begin
                    // Oldest entry sits at the write slot when full
                    d.mem[q.wr] = push_event;
                    d.wr        = nxt(q.wr);
                    d.rd        = nxt(q.rd);
                end
            end
        end
    end

    // State register
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            q <= '0;
        else
            q <= d;
    end

    // Empty FIFO reads as zero
    assign head     = (q.cnt != 4'd0) ? q.mem[q.rd] : '0;
    assign count    = q.cnt;
    assign overflow = q.ovf;

endmodule

// file: logic/kps_keypad_scan.sv
/*
 * Keypad matrix scanner with debounce, event encoding, event FIFO and
 * the register file behind the host serial interface.
 * Assumes the serial slave hands over decoded register reads and writes
 * as single-cycle strobes on this clock; the pins are asynchronous.
 */
`timescale 1ns/1ps
module kps_keypad_scan
#(
    parameter int unsigned SAMPLE_CYC = kps_pkg::KPS_SAMPLE_CYC
)
(
    input  wire logic           clock,
    input  wire logic           rstn,
    input  kps_pkg::kps_reg_req_t reg_req,
    output logic [7:0]          reg_rdata,
    output logic                reg_rvalid,
    input  wire logic [7:0]     row_in,
    output logic [7:0]          row_out,
    output logic [7:0]          row_oe,
    output logic [7:0]          row_pullup_en,
    input  wire logic [9:0]     col_in,
    output logic [9:0]          col_out,
    output logic [9:0]          col_oe,
    output logic [9:0]          col_pullup_en,
    output logic                int_n_out,
    output logic                int_n_oe
);
    import kps_pkg::*;

    // ------------------------------------------------------------------
    // Sub-blocks
    // ------------------------------------------------------------------
    kps_core_t  q;
    kps_core_t  d;
    logic       tick;
    kps_event_t fifo_head;
    logic [3:0] event_count;
    logic       fifo_ovf;
    logic       evt_rd;

    // Sample timing does not depend on bus activity
    kps_timebase
    #(
        .SAMPLE_CYC (SAMPLE_CYC)
    )
    u_timebase
    (
        .clock (clock),
        .rstn  (rstn),
        .tick  (tick)
    );

    kps_event_fifo u_fifo
    (
        .clock      (clock),
        .rstn       (rstn),
        .push       (q.push_v),
        .push_event (q.push_ev),
        .wrap_mode  (q.wrap),
        .pop        (evt_rd),
        .head       (fifo_head),
        .count      (event_count),
        .overflow   (fifo_ovf)
    );

    // Any of the ten event offsets reads and pops the one FIFO
    assign evt_rd = reg_req.rd
                  && reg_req.addr >= KPS_REG_EVT_FIRST
                  && reg_req.addr <= KPS_REG_EVT_LAST;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb
    begin
        logic [2:0] r;
        logic [3:0] c;
        logic       seen;
        logic       pv;
        logic       db;
        logic [6:0] key;
        r    = q.row_idx;
        c    = q.col_idx;
        seen = 1'b0;
        pv   = 1'b0;
        db   = 1'b0;
        key  = '0;
        d    = q;

        // Row pins pass two flops before anything looks at them
        d.row_s1 = row_in;
        d.row_s2 = q.row_s1;

        // One-cycle strobes
        d.wake   = 1'b0;
        d.push_v = 1'b0;
        d.rvalid = 1'b0;

        // Pins stay open-drain lows; only the enables move
        d.row_out   = '0;
        d.row_oe    = '0;
        d.col_out   = '0;
        d.int_n_out = 1'b0;

        // --------------------------------------------------------------
        // Scanner
        // --------------------------------------------------------------
        case (q.st)
            KPS_ST_IDLE:
            begin
                // All enabled matrix columns low, rows left to their pull-ups
                d.col_oe = q.col_en;
                if ((|(~q.row_s2 & q.row_en)) && (|q.col_en))
                begin
                    d.wake    = 1'b1;
                    d.st      = KPS_ST_SCAN;
                    d.col_idx = '0;
                    d.settle  = '0;
                    d.cur     = '0;
                end
            end
            KPS_ST_SCAN:
            begin
                // Drive one matrix column at a time
                for (int k = 0; k < KPS_COLS; k++)
                    d.col_oe[k] = (4'(k) == q.col_idx) && q.col_en[k];
                if (q.settle != KPS_SETTLE_CYC - 3'd1)
                begin
                    d.settle = q.settle + 3'd1;
                end
                else
                begin
                    // Only enabled rows and columns count as keys
                    for (int k = 0; k < KPS_ROWS; k++)
                        d.cur[k][q.col_idx] = ~q.row_s2[k] & q.row_en[k]
                                            & q.col_en[q.col_idx];
                    d.settle = '0;
                    if (q.col_idx == KPS_LAST_COL)
                    begin
                        d.st      = KPS_ST_WALK;
                        d.col_idx = '0;
                        d.row_idx = '0;
                    end
                    else
                    begin
                        d.col_idx = q.col_idx + 4'd1;
                    end
                end
            end
            KPS_ST_WALK:
            begin
                // One key per cycle keeps events in a fixed order
                d.col_oe = '0;
                seen = q.cur[r][c];
                pv   = q.prev[r][c];
                db   = q.deb[r][c];
                key  = 7'({4'b0, r} * KPS_KEYS_PER_ROW)
                     + {3'b0, c} + 7'd1;
                if (seen && pv && !db)
                begin
                    // Seen on two consecutive samples
                    d.push_v  = 1'b1;
                    d.push_ev = '{press: 1'b1, key: key};
                    d.deb[r][c] = 1'b1;
                end
                else if (db && !seen && !pv)
                begin
                    // Absent on two samples, so released a full period
                    d.push_v  = 1'b1;
                    d.push_ev = '{press: 1'b0, key: key};
                    d.deb[r][c] = 1'b0;
                end
                // A held key changes nothing
                if (c == KPS_LAST_COL)
                begin
                    d.col_idx = '0;
                    if (r == KPS_LAST_ROW)
                    begin
                        d.prev = q.cur;
                        if (d.deb == '0 && q.cur == '0)
                            d.st = KPS_ST_IDLE;
                        else
                            d.st = KPS_ST_WAIT;
                    end
                    else
                    begin
                        d.row_idx = r + 3'd1;
                    end
                end
                else
                begin
                    d.col_idx = c + 4'd1;
                end
            end
            KPS_ST_WAIT:
            begin
                // Columns float between samples to save current
                d.col_oe = '0;
                if (tick)
                begin
                    d.st      = KPS_ST_SCAN;
                    d.col_idx = '0;
                    d.settle  = '0;
                    d.cur     = '0;
                end
            end
            default:
            begin
                d.st     = KPS_ST_IDLE;
                d.col_oe = '0;
            end
        endcase

        // --------------------------------------------------------------
        // Status flags: a new event wins over a clear in the same cycle
        // --------------------------------------------------------------
        if (reg_req.wr && reg_req.addr == KPS_REG_STAT)
        begin
            // Pending cannot go while the FIFO still holds events
            if (reg_req.wdata[KPS_STAT_KE_BIT] && event_count == 4'd0)
                d.ke_pend = 1'b0;
            if (reg_req.wdata[KPS_STAT_OVF_BIT])
                d.ovf_pend = 1'b0;
        end
        if (q.push_v)
            d.ke_pend = 1'b1;
        if (fifo_ovf)
            d.ovf_pend = 1'b1;

        // --------------------------------------------------------------
        // Register writes
        // --------------------------------------------------------------
        if (reg_req.wr)
        begin
            case (reg_req.addr)
                KPS_REG_CFG:
                begin
                    d.key_event_irq_enable  = reg_req.wdata[KPS_CFG_KEY_EVENT_IRQ_ENABLE_BIT];
                    d.ovf_ien = reg_req.wdata[KPS_CFG_OVF_IEN_BIT];
                    d.wrap    = reg_req.wdata[KPS_CFG_WRAP_BIT];
                end
                KPS_REG_ROW_EN:    d.row_en      = reg_req.wdata;
                KPS_REG_COL_EN_LO: d.col_en[7:0] = reg_req.wdata;
                KPS_REG_COL_EN_HI: d.col_en[9:8] = reg_req.wdata[1:0];
                default:           d.wrap        = d.wrap;
            endcase
        end

        // --------------------------------------------------------------
        // Register reads, answered on the next cycle
        // --------------------------------------------------------------
        if (reg_req.rd)
        begin
            d.rvalid = 1'b1;
            d.rdata  = '0;
            case (reg_req.addr)
                KPS_REG_CFG:
                begin
                    d.rdata[KPS_CFG_KEY_EVENT_IRQ_ENABLE_BIT]  = q.key_event_irq_enable;
                    d.rdata[KPS_CFG_OVF_IEN_BIT] = q.ovf_ien;
                    d.rdata[KPS_CFG_WRAP_BIT]    = q.wrap;
                end
                KPS_REG_STAT:
                begin
                    d.rdata[KPS_STAT_KE_BIT]  = q.ke_pend;
                    d.rdata[KPS_STAT_OVF_BIT] = q.ovf_pend;
                end
                KPS_REG_COUNT:     d.rdata = {4'b0, event_count};
                KPS_REG_ROW_EN:    d.rdata = q.row_en;
                KPS_REG_COL_EN_LO: d.rdata = q.col_en[7:0];
                KPS_REG_COL_EN_HI: d.rdata = {6'b0, q.col_en[9:8]};
                default:
                begin
                    if (evt_rd)
                        d.rdata = fifo_head;
                end
            endcase
        end

        // Interrupt pin pulls low while an enabled flag stands
        d.irq = (d.ke_pend && d.key_event_irq_enable)
              || (d.ovf_pend && d.ovf_ien);
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            q        <= '0;
            q.st     <= KPS_ST_IDLE;
            q.key_event_irq_enable <= KPS_CFG_RST[KPS_CFG_KEY_EVENT_IRQ_ENABLE_BIT];
            q.ovf_ien<= KPS_CFG_RST[KPS_CFG_OVF_IEN_BIT];
            q.wrap   <= KPS_CFG_RST[KPS_CFG_WRAP_BIT];
            q.row_en <= KPS_ROW_EN_RST;
            q.col_en <= KPS_COL_EN_RST;
            q.row_pu <= KPS_ROW_PU_RST;
            q.col_pu <= KPS_COL_PU_RST;
            q.row_s1 <= KPS_ROW_PU_RST;
            q.row_s2 <= KPS_ROW_PU_RST;
        end
        else
        begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rdata     = q.rdata;
    assign reg_rvalid    = q.rvalid;
    assign row_out       = q.row_out;
    assign row_oe        = q.row_oe;
    assign row_pullup_en = q.row_pu;
    assign col_out       = q.col_out;
    assign col_oe        = q.col_oe;
    assign col_pullup_en = q.col_pu;
    assign int_n_out     = q.int_n_out;
    assign int_n_oe      = q.irq;

endmodule

// file: logic/kps_pkg.sv
/*
 * Shared constants and types for the keypad scanner and its event FIFO.
 * Assumes a single 200 MHz clock and an asynchronous active-low reset.
 */
package kps_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] KPS_REG_CFG        = 8'h01;
    localparam logic [7:0] KPS_REG_STAT       = 8'h02;
    localparam logic [7:0] KPS_REG_COUNT      = 8'h03;
    localparam logic [7:0] KPS_REG_EVT_FIRST  = 8'h04;
    localparam logic [7:0] KPS_REG_EVT_LAST   = 8'h0d;
    localparam logic [7:0] KPS_REG_ROW_EN     = 8'h1d;
    localparam logic [7:0] KPS_REG_COL_EN_LO  = 8'h1e;
    localparam logic [7:0] KPS_REG_COL_EN_HI  = 8'h1f;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int         KPS_CFG_KEY_EVENT_IRQ_ENABLE_BIT  = 0;
    localparam int         KPS_CFG_OVF_IEN_BIT = 3;
    localparam int         KPS_CFG_WRAP_BIT    = 5;
    localparam int         KPS_STAT_KE_BIT     = 0;
    localparam int         KPS_STAT_OVF_BIT    = 3;
    localparam logic [7:0] KPS_CFG_RST         = 8'h00;
    localparam logic [7:0] KPS_ROW_EN_RST      = 8'h00;
    localparam logic [9:0] KPS_COL_EN_RST      = 10'h000;
    localparam logic [7:0] KPS_ROW_PU_RST      = 8'hff;
    localparam logic [9:0] KPS_COL_PU_RST      = 10'h3ff;

    // ------------------------------------------------------------------
    // Matrix, FIFO and timing figures
    // ------------------------------------------------------------------
    localparam int           KPS_ROWS       = 8;
    localparam int           KPS_COLS       = 10;
    localparam logic [3:0]   KPS_FIFO_DEPTH = 4'd10;
    localparam logic [3:0]   KPS_LAST_SLOT  = 4'd9;
    localparam logic [3:0]   KPS_LAST_COL   = 4'd9;
    localparam logic [2:0]   KPS_LAST_ROW   = 3'd7;
    localparam logic [6:0]   KPS_KEYS_PER_ROW = 7'd10;
    localparam logic [2:0]   KPS_SETTLE_CYC = 3'd6;
    localparam int unsigned  KPS_SAMPLE_US  = 25000;
    localparam int unsigned  KPS_CLK_MHZ    = 200;
    localparam int unsigned  KPS_SAMPLE_CYC = KPS_SAMPLE_US * KPS_CLK_MHZ;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       press;
        logic [6:0] key;
    } kps_event_t;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } kps_reg_req_t;

    typedef enum logic [1:0] {
        KPS_ST_IDLE = 2'b00,
        KPS_ST_SCAN = 2'b01,
        KPS_ST_WALK = 2'b10,
        KPS_ST_WAIT = 2'b11
    } kps_scan_t;

    typedef struct packed {
        logic [22:0] cnt;
        logic        tick;
    } kps_tb_t;

    typedef struct packed {
        kps_event_t [9:0] mem;
        logic [3:0]       rd;
        logic [3:0]       wr;
        logic [3:0]       cnt;
        logic             ovf;
    } kps_fifo_t;

    typedef struct packed {
        logic [7:0]       row_s1;
        logic [7:0]       row_s2;
        logic             key_event_irq_enable;
        logic             ovf_ien;
        logic             wrap;
        logic             ke_pend;
        logic             ovf_pend;
        logic [7:0]       row_en;
        logic [9:0]       col_en;
        kps_scan_t        st;
        logic [3:0]       col_idx;
        logic [2:0]       row_idx;
        logic [2:0]       settle;
        logic [7:0][9:0]  cur;
        logic [7:0][9:0]  prev;
        logic [7:0][9:0]  deb;
        logic             wake;
        logic             push_v;
        kps_event_t       push_ev;
        logic [7:0]       rdata;
        logic             rvalid;
        logic [7:0]       row_out;
        logic [7:0]       row_oe;
        logic [7:0]       row_pu;
        logic [9:0]       col_out;
        logic [9:0]       col_oe;
        logic [9:0]       col_pu;
        logic             int_n_out;
        logic             irq;
    } kps_core_t;

endpackage

// file: logic/kps_timebase.sv
/*
 * Free-running sample timebase: one-cycle tick every SAMPLE_CYC clocks.
 * Runs from reset regardless of host register traffic.
 */
`timescale 1ns/1ps
module kps_timebase
#(
    parameter int unsigned SAMPLE_CYC = kps_pkg::KPS_SAMPLE_CYC
)
(
    input  wire logic clock,
    input  wire logic rstn,
    output logic      tick
);
    import kps_pkg::*;

    kps_tb_t q;
    kps_tb_t d;

    // Wrap the counter and flag the wrap
    always_comb
    begin
        d      = q;
        d.tick = 1'b0;
        if (q.cnt == 23'(SAMPLE_CYC - 1))
        begin
            d.cnt  = '0;
            d.tick = 1'b1;
        end
        else
        begin
            d.cnt = q.cnt + 23'd1;
        end
    end

    // State register
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            q <= '0;
        else
            q <= d;
    end

    assign tick = q.tick;

endmodule
